// >>> bench/pnme_phy_model.sv
module pnme_phy_model
(
  input  wire logic        mclk,
  input  wire logic        mmd_wr,
  input  wire logic [4:0]  mmd_target_device_select,
  input  wire logic [15:0] mmd_addr,
  input  wire logic [15:0] mmd_wdata,
  output logic      [15:0] mmd_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // one stored word per device, tagged with the address it belongs to
  logic [15:0] mem [32];
  logic [15:0] tag [32];
  logic [31:0] used = 32'h0000_0000;

  always @(posedge mclk)
    if (mmd_wr)
    begin
      mem[mmd_target_device_select]  <= mmd_wdata;
      tag[mmd_target_device_select]  <= mmd_addr;
      used[mmd_target_device_select] <= 1'b1;
    end

  // unwritten places answer a pattern that tracks the address: its bitwise inverse
  always_comb
    mmd_rdata = (used[mmd_target_device_select] && tag[mmd_target_device_select] == mmd_addr) ?
                mem[mmd_target_device_select] : ~mmd_addr;
endmodule

// >>> bench/pnme_regs_properties.sv
module pnme_regs_checker
#(
  parameter int unsigned MS_CYCLES = 25000
)
(
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        mmd_rd,
  input wire logic        port_in_powerdown,
  input wire logic        nlp_rx_pulse,
  input wire logic        nlp_tx_pulse,
  input wire logic        wake_event,
  input wire logic        energy_powerdown_enable
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence wr_answer;
    !s_axi_awready ##1 s_axi_bvalid;
  endsequence

  a_write_answer: assert property (wr_taken |=> wr_answer)
    else $error("write not answered in time");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read not answered");
  a_rdata_upper: assert property (s_axi_rvalid |->
    s_axi_rdata[31:16] == 16'h0000) else $error("upper read bits set");
  a_mmd_rd_once: assert property (mmd_rd |=> !mmd_rd)
    else $error("device read strobe too long");
  a_tx_in_pd: assert property (nlp_tx_pulse |->
    energy_powerdown_enable && $past(port_in_powerdown))
    else $error("link pulse outside power-down");
  a_tx_spacing: assert property (nlp_tx_pulse |=> !nlp_tx_pulse [*8])
    else $error("link pulses too close");
  a_wake_cause: assert property (wake_event |->
    $past(nlp_rx_pulse) && energy_powerdown_enable)
    else $error("wake without received pulse");
  a_mode_write: assert property ($changed(energy_powerdown_enable) |->
    $rose(s_axi_bvalid)) else $error("mode bit moved without write");
endmodule

bind pnme_regs pnme_regs_checker #(.MS_CYCLES(MS_CYCLES)) i_chk (.*);

// >>> bench/tb_phy_nextpage_mmd_energy_detect_power_down_regs.sv
module tb_phy_nextpage_mmd_energy_detect_power_down_regs;
  timeunit 1ns;
  timeprecision 1ns;
  // short millisecond keeps every period at or below 5000 cycles
  localparam int MS = 5;
  localparam logic [7:0] RA [5] = '{8'h20, 8'h34, 8'h38, 8'h40, 8'h44};
  logic        mclk = 1'h0, reset_n = 1'h0;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, mmd_wr, mmd_rd, nlp_tx_pulse, wake_event;
  logic        energy_powerdown_enable, hit;
  logic        np_rx_strobe = 1'h0, nlp_rx_pulse = 1'h0;
  logic        port_in_powerdown = 1'h0, other_port_powerdown = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] np_rx_word = 16'h0000, mmd_rdata, mmd_addr, mmd_wdata, w, x;
  logic [4:0]  mmd_target_device_select;
  int          errors = 0, check_count = 0, tx_seen = 0, n;

  pnme_regs #(.MS_CYCLES(MS)) i_dut (.*);
  pnme_phy_model i_phy (.*);

  initial
    forever #20 mclk = ~mclk;

  always @(posedge mclk)
    if (nlp_tx_pulse)
      tx_seen++;

  task automatic close_out;
    if (errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    check_count++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d,
                    input logic [1:0] er = 2'h0);
    @(posedge mclk);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    forever
    begin
      @(posedge mclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid)
      begin
        s_axi_bready <= 1'h0;
        chk(s_axi_bresp, er);
        return;
      end
    end
  endtask

  task automatic rc(input logic [7:0] a, input logic [15:0] e,
                    input logic [1:0] er = 2'h0);
    @(posedge mclk);
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    s_axi_araddr <= a;
    forever
    begin
      @(posedge mclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid)
      begin
        s_axi_rready <= 1'h0;
        chk({s_axi_rresp, s_axi_rdata}, {er, 16'h0000, e});
        return;
      end
    end
  endtask

  // cycles from one transmitted link pulse to the next
  task automatic tx_gap(output int g);
    g = 0;
    repeat (6000)
    begin
      @(posedge mclk);
      if (nlp_tx_pulse)
        break;
    end
    do
    begin
      @(posedge mclk);
      g++;
    end
    while (!nlp_tx_pulse && g < 6000);
  endtask

  task automatic rx(output logic h);
    @(posedge mclk);
    nlp_rx_pulse <= 1'h1;
    @(posedge mclk);
    nlp_rx_pulse <= 1'h0;
    @(posedge mclk);
    h = wake_event;
  endtask

  function automatic int tx_ms(input logic [1:0] c);
    return c == 2'h0 ? 1000 : c == 2'h1 ? 768 : c == 2'h2 ? 512 : 256;
  endfunction

  function automatic int gap_ms(input logic [1:0] c);
    return c == 2'h0 ? 64 : c == 2'h1 ? 256 : c == 2'h2 ? 512 : 1000;
  endfunction

  initial
  begin
    repeat (90000)
      @(posedge mclk);
    errors++;
    close_out;
  end

  initial
  begin
    w = 16'($urandom(94774));
    repeat (20)
      @(posedge mclk);
    reset_n <= 1'h1;
    for (int i = 0; i < 5; i++)
      rc(RA[i], 16'h0000);
    rc(8'h04, 16'h0000, 2'h2);
    wr(8'h04, 16'hFFFF, 2'h2);
    wr(8'h20, 16'hFFFF);
    rc(8'h20, 16'h0000);
    np_rx_strobe <= 1'h1;
    np_rx_word <= w;
    @(posedge mclk);
    np_rx_strobe <= 1'h0;
    np_rx_word <= ~w;
    rc(8'h20, w | 16'h4000);
    wr(8'h34, 16'hFFFF);
    rc(8'h34, 16'hC01F);
    for (int d = 3; d <= 7; d += 4)
    begin
      w = 16'($urandom);
      x = 16'($urandom);
      wr(8'h34, 16'(d));
      wr(8'h38, w);
      rc(8'h38, w);
      wr(8'h34, 16'h4000 | 16'(d));
      wr(8'h38, x);
      rc(8'h38, x);
      chk(mmd_rd, 1'h1);
      wr(8'h34, 16'(d));
      rc(8'h38, w);
    end
    x = 16'($urandom);
    x[3] = x[3] | x[15];
    wr(8'h40, x);
    rc(8'h40, x & 16'hFC08);
    wr(8'h44, 16'h2000);
    chk(energy_powerdown_enable, 1'h1);
    port_in_powerdown <= 1'h1;
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h40, 16'h8008 | {2'(c), 13'h0000});
      tx_gap(n);
      chk(n, tx_ms(2'(c)) * MS);
    end
    wr(8'h40, 16'hE000);
    n = tx_seen;
    repeat (1500)
      @(posedge mclk);
    chk(tx_seen - n, 0);
    other_port_powerdown <= 1'h1;
    tx_gap(n);
    chk(n, 256 * MS);
    wr(8'h40, 16'h1000);
    rx(hit);
    chk(hit, 1'h1);
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h40, {4'h0, 2'(c), 10'h000});
      rx(hit);
      repeat (gap_ms(2'(c)) * MS + 15)
        @(posedge mclk);
      rx(hit);
      chk(hit, 1'h0);
      repeat ($urandom_range(10, gap_ms(2'(c)) * MS - 10))
        @(posedge mclk);
      rx(hit);
      chk(hit, 1'h1);
    end
    wr(8'h7C, 16'h0001);
    rc(8'h40, 16'h0000);
    rc(8'h44, 16'h2000);
    close_out;
  end
endmodule

// >>> common/pnme_defines.svh
`ifndef PNME_DEFINES_SVH
`define PNME_DEFINES_SVH

// ---------------------------------------------------------------
// clock and timing
// ---------------------------------------------------------------
`define PNME_MCLK_HZ        25000000
`define PNME_MS_CYCLES      (`PNME_MCLK_HZ / 1000)
`define PNME_TX_PER0_MS     1000
`define PNME_TX_PER1_MS     768
`define PNME_TX_PER2_MS     512
`define PNME_TX_PER3_MS     256
`define PNME_RX_GAP0_MS     64
`define PNME_RX_GAP1_MS     256
`define PNME_RX_GAP2_MS     512
`define PNME_RX_GAP3_MS     1000

// ---------------------------------------------------------------
// register indices; byte address is four times the index
// ---------------------------------------------------------------
`define PNME_IDX_NP_RX      8'h08
`define PNME_IDX_MMD_CTRL   8'h0D
`define PNME_IDX_MMD_DATA   8'h0E
`define PNME_IDX_ENERGY_DETECT_POWER_DOWN_CFG   8'h10
`define PNME_IDX_MODE_CTRL  8'h11
`define PNME_IDX_STATUS     8'h12
`define PNME_IDX_CHIP_RST   8'h1F
`define PNME_BYTE_ADDR(i)   (8'((i) << 2))

// ---------------------------------------------------------------
// field positions, writable masks and reset values
// ---------------------------------------------------------------
`define PNME_NP_ACK         14
`define PNME_MMD_FUNC_HI    15
`define PNME_MMD_FUNC_LO    14
`define PNME_MMD_TARGET_DEVICE_SELECT_HI   4
`define PNME_MMD_MASK       16'hC01F
`define PNME_MMD_RESET      16'h0000
`define PNME_ADDR_RESET     16'h0000
`define PNME_ENERGY_DETECT_POWER_DOWN_TXEN      15
`define PNME_ENERGY_DETECT_POWER_DOWN_TXPER_HI  14
`define PNME_ENERGY_DETECT_POWER_DOWN_TXPER_LO  13
`define PNME_ENERGY_DETECT_POWER_DOWN_SINGLE    12
`define PNME_ENERGY_DETECT_POWER_DOWN_RXGAP_HI  11
`define PNME_ENERGY_DETECT_POWER_DOWN_RXGAP_LO  10
`define PNME_ENERGY_DETECT_POWER_DOWN_INDEP     3
`define PNME_ENERGY_DETECT_POWER_DOWN_MASK      16'hFC08
`define PNME_ENERGY_DETECT_POWER_DOWN_RESET     16'h0000
`define PNME_MODE_EDPWR     13
`define PNME_MODE_MASK      16'h2000
`define PNME_MODE_RESET     16'h0000
`define PNME_CHIP_PHYRST    0

`endif

// >>> common/pnme_pkg.sv
package pnme_pkg;

  typedef enum logic [2:0]
  {
    PNME_R_NONE,
    PNME_R_NP_RX,
    PNME_R_MMD_CTRL,
    PNME_R_MMD_DATA,
    PNME_R_ENERGY_DETECT_POWER_DOWN_CFG,
    PNME_R_MODE_CTRL,
    PNME_R_STATUS,
    PNME_R_CHIP_RST
  } pnme_reg_t;

  typedef enum logic [1:0]
  {
    PNME_MMD_ADDR = 2'h0,
    PNME_MMD_DATA = 2'h1,
    PNME_MMD_RSV2 = 2'h2,
    PNME_MMD_RSV3 = 2'h3
  } pnme_mmd_func_t;

  typedef enum logic [1:0]
  {
    PNME_WK_IDLE  = 2'b00,
    PNME_WK_ARMED = 2'b01
  } pnme_wake_state_t;

  typedef logic [10:0] pnme_ms_t;

endpackage

// >>> design/pnme_nlp_tx.sv
`include "pnme_defines.svh"

module pnme_nlp_tx
(
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       clear,
  input  wire logic       run,
  input  wire logic       ms_tick,
  input  wire logic [1:0] period_sel,
  output logic            pulse_reg
);

  pnme_pkg::pnme_ms_t elapsed_reg;
  pnme_pkg::pnme_ms_t period_ms;

  function automatic pnme_pkg::pnme_ms_t tx_period(input logic [1:0] s);
    case (s)
      2'h0:    tx_period = 11'(`PNME_TX_PER0_MS);
      2'h1:    tx_period = 11'(`PNME_TX_PER1_MS);
      2'h2:    tx_period = 11'(`PNME_TX_PER2_MS);
      default: tx_period = 11'(`PNME_TX_PER3_MS);
    endcase
  endfunction

  assign period_ms = tx_period(period_sel);

  // ---------------------------------------------------------------
  // interval counter in milliseconds
  // ---------------------------------------------------------------
  // a period change takes effect at once; a count already past the
  // new period fires on the next tick rather than wrapping
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      elapsed_reg <= 11'h000;
      pulse_reg   <= 1'b0;
    end
    else if (clear || !run)
    begin
      elapsed_reg <= 11'h000;
      pulse_reg   <= 1'b0;
    end
    else if (ms_tick && (elapsed_reg >= period_ms - 11'h001))
    begin
      elapsed_reg <= 11'h000;
      pulse_reg   <= 1'b1;
    end
    else
    begin
      if (ms_tick)
        elapsed_reg <= elapsed_reg + 11'h001;
      pulse_reg <= 1'b0;
    end
  end

endmodule

// >>> design/pnme_regs.sv
// Design decision made here: the AXI4-Lite slave port.
`include "pnme_defines.svh"

module pnme_regs
#(
  parameter int unsigned MS_CYCLES = `PNME_MS_CYCLES
)
(
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  input  wire logic        np_rx_strobe,
  input  wire logic [15:0] np_rx_word,
  input  wire logic [15:0] mmd_rdata,
  output logic             mmd_wr,
  output logic             mmd_rd,
  output logic [4:0]       mmd_target_device_select,
  output logic [15:0]      mmd_addr,
  output logic [15:0]      mmd_wdata,
  input  wire logic        port_in_powerdown,
  input  wire logic        other_port_powerdown,
  input  wire logic        nlp_rx_pulse,
  output logic             nlp_tx_pulse,
  output logic             wake_event,
  output logic             energy_powerdown_enable
);

  localparam int unsigned PRE_W = $clog2(MS_CYCLES + 1);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic                awready_reg;
  logic                wready_reg;
  logic                bvalid_reg;
  logic [1:0]          bresp_reg;
  logic                arready_reg;
  logic                rvalid_reg;
  logic [31:0]         rdata_reg;
  logic [1:0]          rresp_reg;
  logic [7:0]          awaddr_reg;
  logic [31:0]         wdata_reg;
  logic [3:0]          wstrb_reg;
  logic [15:0]         np_rx_reg;
  logic [15:0]         mmd_ctrl_reg;
  logic [15:0]         mmd_addr_reg;
  logic [15:0]         mmd_wdata_reg;
  logic                mmd_wr_reg;
  logic                mmd_rd_reg;
  logic [15:0]         energy_detect_power_down_cfg_reg;
  logic [15:0]         mode_reg;
  logic                phy_rst_reg;
  logic [PRE_W-1:0]    pre_reg;
  logic                ms_tick_reg;
  logic                do_write;
  logic                do_read;
  pnme_pkg::pnme_reg_t wr_sel;
  pnme_pkg::pnme_reg_t rd_sel;
  pnme_pkg::pnme_mmd_func_t mmd_func;
  logic                pd_active;
  logic                tx_run;
  logic                wake_armed;
  logic [15:0]         rd_value;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic pnme_pkg::pnme_reg_t reg_decode(input logic [7:0] a);
    if (a == `PNME_BYTE_ADDR(`PNME_IDX_NP_RX))
      reg_decode = pnme_pkg::PNME_R_NP_RX;
    else if (a == `PNME_BYTE_ADDR(`PNME_IDX_MMD_CTRL))
      reg_decode = pnme_pkg::PNME_R_MMD_CTRL;
    else if (a == `PNME_BYTE_ADDR(`PNME_IDX_MMD_DATA))
      reg_decode = pnme_pkg::PNME_R_MMD_DATA;
    else if (a == `PNME_BYTE_ADDR(`PNME_IDX_ENERGY_DETECT_POWER_DOWN_CFG))
      reg_decode = pnme_pkg::PNME_R_ENERGY_DETECT_POWER_DOWN_CFG;
    else if (a == `PNME_BYTE_ADDR(`PNME_IDX_MODE_CTRL))
      reg_decode = pnme_pkg::PNME_R_MODE_CTRL;
    else if (a == `PNME_BYTE_ADDR(`PNME_IDX_STATUS))
      reg_decode = pnme_pkg::PNME_R_STATUS;
    else if (a == `PNME_BYTE_ADDR(`PNME_IDX_CHIP_RST))
      reg_decode = pnme_pkg::PNME_R_CHIP_RST;
    else
      reg_decode = pnme_pkg::PNME_R_NONE;
  endfunction

  // byte-lane merge restricted to the writable bits
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  s,
                                          input logic [15:0] m);
    logic [15:0] n;
    n = old;
    if (s[0])
      n[7:0] = d[7:0];
    if (s[1])
      n[15:8] = d[15:8];
    merge16 = (n & m) | (old & ~m);
  endfunction

  assign wr_sel   = reg_decode(awaddr_reg);
  assign rd_sel   = reg_decode(s_axi_araddr);
  assign mmd_func = pnme_pkg::pnme_mmd_func_t'(
                      mmd_ctrl_reg[`PNME_MMD_FUNC_HI:`PNME_MMD_FUNC_LO]);
  assign do_write = !awready_reg && !wready_reg && !bvalid_reg;
  assign do_read  = s_axi_arvalid && arready_reg;

  // ---------------------------------------------------------------
  // write channels
  // ---------------------------------------------------------------
  // address and data are taken independently; the write lands once
  // both are held, and both readies return once the response is accepted
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= 2'h0;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && awready_reg)
      begin
        awready_reg <= 1'b0;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_reg)
      begin
        wready_reg <= 1'b0;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (do_write)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= (wr_sel == pnme_pkg::PNME_R_NONE) ? 2'h2 : 2'h0;
      end
      else if (bvalid_reg && s_axi_bready)
      begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  always_comb
  begin
    rd_value = 16'h0000;
    case (rd_sel)
      pnme_pkg::PNME_R_NP_RX:     rd_value = np_rx_reg;
      pnme_pkg::PNME_R_MMD_CTRL:  rd_value = mmd_ctrl_reg;
      pnme_pkg::PNME_R_MMD_DATA:
        rd_value = (mmd_func == pnme_pkg::PNME_MMD_ADDR) ?
                   mmd_addr_reg : mmd_rdata;
      pnme_pkg::PNME_R_ENERGY_DETECT_POWER_DOWN_CFG:  rd_value = energy_detect_power_down_cfg_reg;
      pnme_pkg::PNME_R_MODE_CTRL: rd_value = mode_reg;
      pnme_pkg::PNME_R_STATUS:
        rd_value = {13'h0000, wake_armed, tx_run, pd_active};
      default:                    rd_value = 16'h0000;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= 2'h0;
    end
    else if (do_read)
    begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= {16'h0000, rd_value};
      rresp_reg   <= (rd_sel == pnme_pkg::PNME_R_NONE) ? 2'h2 : 2'h0;
    end
    else if (rvalid_reg && s_axi_rready)
    begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // partner next page
  // ---------------------------------------------------------------
  // bit 14 is forced to one: it reports receipt, not the partner's
  // own acknowledge bit
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      np_rx_reg <= 16'h0000;
    else if (np_rx_strobe)
    begin
      np_rx_reg              <= np_rx_word;
      np_rx_reg[`PNME_NP_ACK] <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // indirect device access
  // ---------------------------------------------------------------
  // reserved function codes are stored as written and act as data
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      mmd_ctrl_reg <= `PNME_MMD_RESET;
    else if (do_write && wr_sel == pnme_pkg::PNME_R_MMD_CTRL)
      mmd_ctrl_reg <= merge16(mmd_ctrl_reg, wdata_reg, wstrb_reg,
                              `PNME_MMD_MASK);
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mmd_addr_reg  <= `PNME_ADDR_RESET;
      mmd_wdata_reg <= `PNME_ADDR_RESET;
      mmd_wr_reg    <= 1'b0;
    end
    else
    begin
      mmd_wr_reg <= 1'b0;
      if (do_write && wr_sel == pnme_pkg::PNME_R_MMD_DATA)
      begin
        if (mmd_func == pnme_pkg::PNME_MMD_ADDR)
          mmd_addr_reg <= merge16(mmd_addr_reg, wdata_reg, wstrb_reg,
                                  16'hFFFF);
        else
        begin
          mmd_wdata_reg <= merge16(mmd_wdata_reg, wdata_reg, wstrb_reg,
                                   16'hFFFF);
          mmd_wr_reg    <= 1'b1;
        end
      end
    end
  end

  // mmd_rdata is taken in the cycle before the read strobe is made
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      mmd_rd_reg <= 1'b0;
    else
      mmd_rd_reg <= do_read && rd_sel == pnme_pkg::PNME_R_MMD_DATA &&
                    mmd_func != pnme_pkg::PNME_MMD_ADDR;
  end

  // ---------------------------------------------------------------
  // power-down configuration and mode
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      phy_rst_reg <= 1'b0;
    else
      phy_rst_reg <= do_write && wr_sel == pnme_pkg::PNME_R_CHIP_RST &&
                     wstrb_reg[0] && wdata_reg[`PNME_CHIP_PHYRST];
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      energy_detect_power_down_cfg_reg <= `PNME_ENERGY_DETECT_POWER_DOWN_RESET;
    else if (phy_rst_reg)
      energy_detect_power_down_cfg_reg <= `PNME_ENERGY_DETECT_POWER_DOWN_RESET;
    else if (do_write && wr_sel == pnme_pkg::PNME_R_ENERGY_DETECT_POWER_DOWN_CFG)
      energy_detect_power_down_cfg_reg <= merge16(energy_detect_power_down_cfg_reg, wdata_reg, wstrb_reg,
                              `PNME_ENERGY_DETECT_POWER_DOWN_MASK);
  end

  // not cleared by the phy reset pulse
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      mode_reg <= `PNME_MODE_RESET;
    else if (do_write && wr_sel == pnme_pkg::PNME_R_MODE_CTRL)
      mode_reg <= merge16(mode_reg, wdata_reg, wstrb_reg,
                          `PNME_MODE_MASK);
  end

  // ---------------------------------------------------------------
  // millisecond prescaler shared by both timers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pre_reg     <= '0;
      ms_tick_reg <= 1'b0;
    end
    else if (pre_reg == PRE_W'(MS_CYCLES - 1))
    begin
      pre_reg     <= '0;
      ms_tick_reg <= 1'b1;
    end
    else
    begin
      pre_reg     <= pre_reg + PRE_W'(1);
      ms_tick_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // link pulse generation and wake detection
  // ---------------------------------------------------------------
  assign pd_active = mode_reg[`PNME_MODE_EDPWR] && port_in_powerdown;
  assign tx_run    = energy_detect_power_down_cfg_reg[`PNME_ENERGY_DETECT_POWER_DOWN_TXEN] && pd_active &&
                     (energy_detect_power_down_cfg_reg[`PNME_ENERGY_DETECT_POWER_DOWN_INDEP] ||
                      other_port_powerdown);

  pnme_nlp_tx u_nlp_tx
  (
    .mclk       (mclk),
    .reset_n    (reset_n),
    .clear      (phy_rst_reg),
    .run        (tx_run),
    .ms_tick    (ms_tick_reg),
    .period_sel (energy_detect_power_down_cfg_reg[`PNME_ENERGY_DETECT_POWER_DOWN_TXPER_HI:`PNME_ENERGY_DETECT_POWER_DOWN_TXPER_LO]),
    .pulse_reg  (nlp_tx_pulse)
  );

  pnme_wake_det u_wake_det
  (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .clear     (phy_rst_reg),
    .active    (pd_active),
    .single    (energy_detect_power_down_cfg_reg[`PNME_ENERGY_DETECT_POWER_DOWN_SINGLE]),
    .ms_tick   (ms_tick_reg),
    .gap_sel   (energy_detect_power_down_cfg_reg[`PNME_ENERGY_DETECT_POWER_DOWN_RXGAP_HI:`PNME_ENERGY_DETECT_POWER_DOWN_RXGAP_LO]),
    .nlp_rx    (nlp_rx_pulse),
    .wake_reg  (wake_event),
    .armed_reg (wake_armed)
  );

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign s_axi_awready           = awready_reg;
  assign s_axi_wready            = wready_reg;
  assign s_axi_bvalid            = bvalid_reg;
  assign s_axi_bresp             = bresp_reg;
  assign s_axi_arready           = arready_reg;
  assign s_axi_rvalid            = rvalid_reg;
  assign s_axi_rdata             = rdata_reg;
  assign s_axi_rresp             = rresp_reg;
  assign mmd_wr                  = mmd_wr_reg;
  assign mmd_rd                  = mmd_rd_reg;
  assign mmd_target_device_select               = mmd_ctrl_reg[`PNME_MMD_TARGET_DEVICE_SELECT_HI:0];
  assign mmd_addr                = mmd_addr_reg;
  assign mmd_wdata               = mmd_wdata_reg;
  assign energy_powerdown_enable = mode_reg[`PNME_MODE_EDPWR];

endmodule

// >>> design/pnme_wake_det.sv
`include "pnme_defines.svh"

module pnme_wake_det
(
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       clear,
  input  wire logic       active,
  input  wire logic       single,
  input  wire logic       ms_tick,
  input  wire logic [1:0] gap_sel,
  input  wire logic       nlp_rx,
  output logic            wake_reg,
  output logic            armed_reg
);

  pnme_pkg::pnme_wake_state_t state_reg;
  pnme_pkg::pnme_ms_t         gap_reg;
  pnme_pkg::pnme_ms_t         gap_ms;

  function automatic pnme_pkg::pnme_ms_t rx_gap(input logic [1:0] s);
    case (s)
      2'h0:    rx_gap = 11'(`PNME_RX_GAP0_MS);
      2'h1:    rx_gap = 11'(`PNME_RX_GAP1_MS);
      2'h2:    rx_gap = 11'(`PNME_RX_GAP2_MS);
      default: rx_gap = 11'(`PNME_RX_GAP3_MS);
    endcase
  endfunction

  assign gap_ms = rx_gap(gap_sel);

  // ---------------------------------------------------------------
  // pulse pairing
  // ---------------------------------------------------------------
  // gap resolution is one millisecond tick; a late second pulse
  // opens a fresh window instead of being dropped
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= pnme_pkg::PNME_WK_IDLE;
      gap_reg   <= 11'h000;
      wake_reg  <= 1'b0;
    end
    else if (clear || !active)
    begin
      state_reg <= pnme_pkg::PNME_WK_IDLE;
      gap_reg   <= 11'h000;
      wake_reg  <= 1'b0;
    end
    else
    begin
      wake_reg <= 1'b0;
      case (state_reg)
        pnme_pkg::PNME_WK_IDLE:
        begin
          gap_reg <= 11'h000;
          if (nlp_rx && single)
            wake_reg <= 1'b1;
          else if (nlp_rx)
            state_reg <= pnme_pkg::PNME_WK_ARMED;
        end
        pnme_pkg::PNME_WK_ARMED:
        begin
          if (nlp_rx && (single || gap_reg <= gap_ms))
          begin
            wake_reg  <= 1'b1;
            state_reg <= pnme_pkg::PNME_WK_IDLE;
          end
          else if (nlp_rx)
            gap_reg <= 11'h000;
          else if (ms_tick && gap_reg <= gap_ms)
            gap_reg <= gap_reg + 11'h001;
        end
        default:
          state_reg <= pnme_pkg::PNME_WK_IDLE;
      endcase
    end
  end

  assign armed_reg = (state_reg == pnme_pkg::PNME_WK_ARMED);

endmodule
